//--- rtl/overcurrent_supervision.sv
// overcurrent supervision: three instantaneous and three inverse-time
// elements (phase, ground, negative sequence) with torque control,
// block trip, bypass time and open-pole blocking, set over apb.
// assumes currents and flags on clk_sys;
// contact-derived inputs are synchronised here.
// Operation
// (R01) torque setting: nondirectional, forward, reverse
// (R02) phase source: phase or positive-sequence unit
// (R03) ground source: ground or negative-sequence unit
// (R04) negative-sequence elements use negative-sequence unit
// (R05) block trip before trip prevents operation
// (R06) block trip after trip resets it
// (R07) block trip only when configured as source
// (R08) bypass time makes time element instantaneous
// (R09) open pole blocks ground, negative-sequence pickup
// (R10) instant torque disable blocks directional pickup
// (R11) timed torque disable blocks directional pickup
// (R12) iec inverse curve time
// (R13) iec long-time curve time
// (R14) iec short-time curve time
// (R15) ieee very inverse curve time
// (R16) moderately inverse curve time
// (R17) us extremely inverse curve time
// (R18) us short-time curve time
// (R19) pickup at 1.05, dropout at 1.00
// (R20) drop-out resets integrator immediately
// (R21) ratio above twenty clamped to twenty
// (R22) directional pickup follows selected unit flag
// (R23) trip when integration reaches curve time
`timescale 1ns/100ps
`default_nettype none
module overcurrent_supervision
  import ocp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ocp_pkg::CUR_W-1:0] phase_current,
  input wire logic [ocp_pkg::CUR_W-1:0] ground_current,
  input wire logic [ocp_pkg::CUR_W-1:0] negseq_current,
  input wire logic [3:0] instant_forward_indication,
  input wire logic [3:0] instant_reverse_indication,
  input wire logic [3:0] timed_forward_indication,
  input wire logic [3:0] timed_reverse_indication,
  input wire logic [2:0] instant_torque_disable,
  input wire logic [2:0] timed_torque_disable,
  input wire logic single_pole_open_block,
  input wire logic [2:0] bypass_time,
  input wire logic [5:0] block_trip,
  output logic [2:0] instant_pickup,
  output logic [2:0] instant_trip,
  output logic [2:0] timed_pickup,
  output logic [2:0] timed_trip
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // directional unit that supervises an element class
  function automatic int dir_src(input int el, input logic sel);
    if (el == EL_PH) return sel ? DIR_POS : DIR_PH; // R02
    if (el == EL_GND) return sel ? DIR_NEG : DIR_GND; // R03
    return DIR_NEG; // R04
  endfunction

  // torque control: permission to pick up for one element
  function automatic logic permit_fn(input logic [1:0] tq, input logic fwd,
                                     input logic rev, input logic tdis);
    logic ok;
    ok = 1'b0;
    case (torque_t'(tq))
      TQ_NONDIR: ok = 1'b1; // R01
      TQ_FWD: ok = fwd & !tdis; // R22
      TQ_REV: ok = rev & !tdis; // R22
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // ----------------------------------------
  // contact input synchronisers
  // ----------------------------------------
  logic [8:0] sync1_q;
  logic [8:0] sync2_q;
  // contacts are asynchronous to clk_sys; two stages before any use
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {bypass_time, block_trip};
      sync2_q <= sync1_q;
    end
  end
  wire [5:0] blk_in = sync2_q[5:0];
  wire [2:0] byp_in = sync2_q[8:6];
  logic pole_sync1_q;
  logic sync_pole_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) pole_sync1_q <= 1'b0;
    else pole_sync1_q <= single_pole_open_block;
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) sync_pole_q <= 1'b0;
    else sync_pole_q <= pole_sync1_q;
  end
  wire pole_open = sync_pole_q;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [CFG_W-1:0] cfg_q [6];
  logic [DSET_W-1:0] dset_q [3];
  logic [31:0] prdata_q;
  logic [11:0] status;
  wire [3:0] idx = paddr[5:2];
  wire mapped = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00) && (idx < 4'(REG_COUNT));
  wire setup = psel & !penable;
  wire wr_acc = psel & penable & pready & pwrite & mapped;
  wire [3:0] cfg_base = REG_CFG0[5:2];
  wire [3:0] dset_base = REG_DSET0[5:2];
  wire [3:0] stat_idx = REG_STATUS[5:2];
  wire is_cfg = (idx >= cfg_base) && (idx < dset_base);
  wire is_dset = (idx >= dset_base) && (idx < stat_idx);
  wire [3:0] cfg_i = idx - cfg_base;
  wire [3:0] dset_i = idx - dset_base;

  // read mux; unused high bits read as zero
  logic [31:0] rd_val;
  always_comb begin
    rd_val = '0;
    if (is_cfg) rd_val = 32'(cfg_q[cfg_i[2:0]]);
    else if (is_dset) rd_val = 32'(dset_q[dset_i[1:0]]);
    else if (idx == stat_idx) rd_val = 32'(status);
  end

  // register writes in the access cycle, read capture in the setup cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 6; i++) cfg_q[i] <= CFG_RST;
      for (int i = 0; i < 3; i++) dset_q[i] <= DSET_RST;
      prdata_q <= '0;
    end else begin
      if (wr_acc && is_cfg) cfg_q[cfg_i[2:0]] <= pwdata[CFG_W-1:0];
      if (wr_acc && is_dset) dset_q[dset_i[1:0]] <= pwdata[DSET_W-1:0];
      if (setup) prdata_q <= rd_val;
    end
  end

  // zero wait states
  assign pready = 1'b1;
  assign pslverr = psel & penable & !mapped;
  assign prdata = prdata_q;

  // ----------------------------------------
  // microsecond tick for the integrators
  // ----------------------------------------
  logic [TICK_W-1:0] tick_q;
  wire tick = (tick_q == TICK_W'(TICK_CYCLES - 1));
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) tick_q <= '0;
    else tick_q <= tick ? '0 : tick_q + TICK_W'(1);
  end

  // ----------------------------------------
  // element permissions
  // ----------------------------------------
  wire [CUR_W-1:0] cur [3];
  assign cur[EL_PH] = phase_current;
  assign cur[EL_GND] = ground_current;
  assign cur[EL_NEG] = negseq_current;
  wire [2:0] pole_blk = {pole_open, pole_open, 1'b0}; // R09
  wire [2:0] inst_perm;
  wire [2:0] time_perm;
  wire [5:0] blk_act;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_perm
      localparam int CI = g;
      localparam int CT = g + 3;
      wire [1:0] tq_i = cfg_q[CI][F_TQ_LSB +: 2];
      wire [1:0] tq_t = cfg_q[CT][F_TQ_LSB +: 2];
      wire [1:0] ds_i = 2'(dir_src(g, cfg_q[CI][F_TYPE]));
      wire [1:0] ds_t = 2'(dir_src(g, cfg_q[CT][F_TYPE]));
      assign inst_perm[g] = permit_fn(tq_i, instant_forward_indication[ds_i],
                                      instant_reverse_indication[ds_i],
                                      instant_torque_disable[g]) & !pole_blk[g]; // R10
      assign time_perm[g] = permit_fn(tq_t, timed_forward_indication[ds_t],
                                      timed_reverse_indication[ds_t],
                                      timed_torque_disable[g]) & !pole_blk[g]; // R11
      assign blk_act[CI] = blk_in[CI] & cfg_q[CI][F_BLKEN]; // R07
      assign blk_act[CT] = blk_in[CT] & cfg_q[CT][F_BLKEN]; // R07
    end
  endgenerate

  // ----------------------------------------
  // instantaneous elements
  // ----------------------------------------
  logic [2:0] ipk_q;
  logic [2:0] itr_q;
  logic [2:0] ipk_d;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ipk_d[i] = cfg_q[i][F_EN] & pickup_next(cur[i], cfg_q[i][CUR_W-1:0], ipk_q[i]); // R19
    end
  end
  // block trip is a level: it both prevents and withdraws the trip
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ipk_q <= '0;
      itr_q <= '0;
    end else begin
      ipk_q <= ipk_d;
      itr_q <= ipk_d & inst_perm & ~blk_act[2:0]; // R05 R06
    end
  end

  // ----------------------------------------
  // time elements
  // ----------------------------------------
  wire [2:0] tpk;
  wire [2:0] ttr;
  logic [2:0] ttr_q;
  logic [2:0] tpk_q;
  generate
    for (g = 0; g < 3; g++) begin : g_toc
      toc_if lnk ();
      assign lnk.current = cur[g];
      assign lnk.pickup = cfg_q[g+3][CUR_W-1:0];
      assign lnk.enable = cfg_q[g+3][F_EN];
      assign lnk.dial = dset_q[g][DIAL_W-1:0];
      assign lnk.curve = dset_q[g][F_CRV_LSB +: CRV_W];
      assign lnk.permit = time_perm[g];
      assign lnk.bypass = byp_in[g];
      assign tpk[g] = lnk.picked;
      assign ttr[g] = lnk.trip;
      timed_element u_el (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .tick(tick),
        .el(lnk.elem)
      );
    end
  endgenerate

  // time trip gated by block trip, registered for clean outputs
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tpk_q <= '0;
      ttr_q <= '0;
    end else begin
      tpk_q <= tpk;
      ttr_q <= ttr & ~blk_act[5:3]; // R05 R06
    end
  end

  // ----------------------------------------
  // outputs and status
  // ----------------------------------------
  assign status = {ttr_q, itr_q, tpk_q, ipk_q & inst_perm};
  assign instant_pickup = ipk_q & inst_perm;
  assign instant_trip = itr_q;
  assign timed_pickup = tpk_q;
  assign timed_trip = ttr_q;
endmodule // overcurrent_supervision
`default_nettype wire

//--- include/ocp_pkg.sv
// constants, types and shared helpers of the overcurrent supervision block
// assumes one 25 MHz system clock and a 32-bit apb register port
package ocp_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned TICK_PERIOD_NS = 1000;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 5;

  // ----------------------------------------
  // widths and fixed-point scales
  // ----------------------------------------
  localparam int CUR_W = 16;
  localparam int DIAL_W = 10;
  localparam int CRV_W = 3;
  localparam int NUM_W = 48;
  localparam int ACC_W = 41;
  localparam logic [NUM_W-1:0] ACC_FULL = 48'h0100_0000_0000;
  localparam logic [15:0] IS_ONE = 16'h0100;
  localparam logic [15:0] IS_MAX = 16'h1400;
  localparam logic [31:0] IS_SQ_ONE = 32'h0001_0000;
  localparam logic [15:0] LN2_Q8 = 16'h00B1;
  localparam logic [7:0] P_SHORT = 8'h04;
  localparam logic [7:0] P_MOD = 8'h02;
  localparam logic [15:0] DIAL_ONE = 16'h0064;
  localparam logic [7:0] PU_NUM = 8'h69;
  localparam logic [7:0] PU_DEN = 8'h64;

  // ----------------------------------------
  // curve coefficients in microseconds
  // ----------------------------------------
  localparam logic [31:0] K_IEC_INV = 32'h0002_22E0;
  localparam logic [31:0] K_IEC_LONG = 32'h0727_0E00;
  localparam logic [31:0] K_IEC_SHORT = 32'h0000_C350;
  localparam logic [31:0] A_IEEE_VERY = 32'h0001_DB64;
  localparam logic [31:0] K_IEEE_VERY = 32'h01AE_4C40;
  localparam logic [31:0] A_IEEE_MOD = 32'h0000_5848;
  localparam logic [31:0] K_IEEE_MOD = 32'h0000_28A0;
  localparam logic [31:0] A_US_EXT = 32'h0000_8980;
  localparam logic [31:0] K_US_EXT = 32'h0056_8470;
  localparam logic [31:0] A_US_SHORT = 32'h0000_0A3C;
  localparam logic [31:0] K_US_SHORT = 32'h0000_0D5C;

  // ----------------------------------------
  // enumerations
  // ----------------------------------------
  typedef enum logic [1:0] {TQ_NONDIR = 2'h0, TQ_FWD = 2'h1, TQ_REV = 2'h2} torque_t;
  typedef enum logic [2:0] {
    CRV_IEC_INV = 3'h0, CRV_IEC_LONG = 3'h1, CRV_IEC_SHORT = 3'h2, CRV_IEEE_VERY = 3'h3,
    CRV_IEEE_MOD = 3'h4, CRV_US_EXT = 3'h5, CRV_US_SHORT = 3'h6
  } curve_t;
  typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_TIMING = 3'h2, ST_TRIP = 3'h4} toc_state_t;
  localparam int EL_PH = 0;
  localparam int EL_GND = 1;
  localparam int EL_NEG = 2;
  localparam int DIR_PH = 0;
  localparam int DIR_POS = 1;
  localparam int DIR_GND = 2;
  localparam int DIR_NEG = 3;

  // ----------------------------------------
  // register map and fields
  // ----------------------------------------
  localparam logic [7:0] REG_CFG0 = 8'h00;
  localparam logic [7:0] REG_DSET0 = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h24;
  localparam int REG_COUNT = 10;
  localparam int F_TQ_LSB = 16;
  localparam int F_TYPE = 18;
  localparam int F_BLKEN = 19;
  localparam int F_EN = 20;
  localparam int CFG_W = 21;
  localparam int F_CRV_LSB = 10;
  localparam int DSET_W = 13;
  localparam logic [CFG_W-1:0] CFG_RST = 21'h00_0000;
  localparam logic [DSET_W-1:0] DSET_RST = 13'h0064;
  localparam int S_IPU = 0;
  localparam int S_TPU = 3;
  localparam int S_ITR = 6;
  localparam int S_TTR = 9;

  // pickup with hysteresis: on above 1.05 x setting, off at 1 x setting
  function automatic logic pickup_next(input logic [CUR_W-1:0] cur,
                                       input logic [CUR_W-1:0] pick, input logic prev);
    logic [23:0] a;
    logic [23:0] b;
    a = cur * PU_DEN;
    b = pick * PU_NUM;
    return prev ? (cur > pick) : (a > b);
  endfunction
endpackage

//--- include/toc_if.sv
// signals between the supervision top and one time element
// assumes both ends run on the same system clock
`timescale 1ns/100ps
`default_nettype none
interface toc_if;
  logic [15:0] current;
  logic [15:0] pickup;
  logic [2:0] curve;
  logic [9:0] dial;
  logic enable;
  logic permit;
  logic bypass;
  logic picked;
  logic trip;
  modport ctl (output current, pickup, curve, dial, enable, permit, bypass,
               input picked, trip);
  modport elem (input current, pickup, curve, dial, enable, permit, bypass,
                output picked, trip);
endinterface
`default_nettype wire

//--- rtl/timed_element.sv
// one inverse-time overcurrent element: curve time and time integrator
// assumes current and pickup in one unit, top's clock
`timescale 1ns/100ps
`default_nettype none
module timed_element
  import ocp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic tick,
  toc_if.elem el
);
  // ----------------------------------------
  // current ratio, clamped at twenty
  // ----------------------------------------
  wire [CUR_W-1:0] pick_nz = (el.pickup == '0) ? CUR_W'(1) : el.pickup;
  wire [23:0] ratio_raw = {el.current, 8'h00} / {8'h00, pick_nz};
  wire [15:0] is_q8 = (ratio_raw > {8'h00, IS_MAX}) ? IS_MAX : ratio_raw[15:0]; // R21
  wire [15:0] den_lin = is_q8 - IS_ONE;
  wire [31:0] den_sq = (is_q8 * is_q8) - IS_SQ_ONE;
  // log2 in q8 from the leading one, linear between octaves
  logic [3:0] msb;
  always_comb begin
    msb = 4'h8;
    for (int i = 8; i < 16; i++) begin
      if (is_q8[i]) msb = 4'(i);
    end
  end
  wire [15:0] frac = 16'((is_q8 << (5'd16 - {1'b0, msb})) >> 8) & 16'h00FF;
  wire [15:0] log2_q8 = {4'h0, msb - 4'h8, 8'h00} | frac;
  wire [31:0] ln_q8 = (log2_q8 * LN2_Q8) >> 8;
  // small powers of is approximated as 1 + p ln(is)
  wire [NUM_W-1:0] lnd_s = NUM_W'(ln_q8 * P_SHORT) | NUM_W'(1);
  wire [NUM_W-1:0] lnd_m = NUM_W'(ln_q8 * P_MOD) | NUM_W'(1);
  wire [NUM_W-1:0] dlin = (den_lin == '0) ? NUM_W'(1) : NUM_W'(den_lin);
  wire [NUM_W-1:0] dsq = (den_sq == '0) ? NUM_W'(1) : NUM_W'(den_sq);

  // ----------------------------------------
  // operate time in microseconds
  // ----------------------------------------
  logic [NUM_W-1:0] add_us;
  logic [NUM_W-1:0] frc_us;
  logic dial_all;
  always_comb begin
    add_us = '0;
    dial_all = 1'b1;
    case (curve_t'(el.curve))
      CRV_IEC_LONG: frc_us = (NUM_W'(K_IEC_LONG) << 8) / dlin; // R13
      CRV_IEC_SHORT: frc_us = NUM_W'(K_IEC_SHORT) * 25600 / lnd_s; // R14
      CRV_IEEE_VERY: begin
        add_us = NUM_W'(A_IEEE_VERY);
        dial_all = 1'b0;
        frc_us = (NUM_W'(K_IEEE_VERY) << 16) / dsq; // R15
      end
      CRV_IEEE_MOD: begin
        add_us = NUM_W'(A_IEEE_MOD);
        dial_all = 1'b0;
        frc_us = NUM_W'(K_IEEE_MOD) * 25600 / lnd_m; // R16
      end
      CRV_US_EXT: begin
        add_us = NUM_W'(A_US_EXT);
        frc_us = (NUM_W'(K_US_EXT) << 16) / dsq; // R17
      end
      CRV_US_SHORT: begin
        add_us = NUM_W'(A_US_SHORT);
        frc_us = NUM_W'(K_US_SHORT) * 25600 / lnd_m; // R18
      end
      default: frc_us = (NUM_W'(K_IEC_INV) << 8) / dlin; // R12
    endcase
  end
  wire [NUM_W-1:0] dial48 = NUM_W'(el.dial);
  wire [NUM_W-1:0] t_all = ((add_us + frc_us) * dial48) / NUM_W'(DIAL_ONE);
  wire [NUM_W-1:0] t_frc = add_us + (frc_us * dial48) / NUM_W'(DIAL_ONE);
  wire [NUM_W-1:0] t_us = dial_all ? t_all : t_frc;
  wire [NUM_W-1:0] inc = ACC_FULL / ((t_us == '0) ? NUM_W'(1) : t_us);

  // ----------------------------------------
  // pickup, integrator and trip state
  // ----------------------------------------
  toc_state_t st_q, st_d;
  logic [ACC_W-1:0] acc_q, acc_d;
  logic pk_q;
  wire run = pk_q & el.permit;
  wire [NUM_W-1:0] acc_sum = NUM_W'(acc_q) + inc;
  wire done = acc_sum >= ACC_FULL;

  // integration ends at once on any drop, so a new pickup times from zero
  always_comb begin
    st_d = st_q;
    acc_d = acc_q;
    case (st_q)
      ST_IDLE: begin
        acc_d = '0;
        if (run) st_d = ST_TIMING;
      end
      ST_TIMING: begin
        if (!run) begin
          st_d = ST_IDLE; // R20
          acc_d = '0;
        end else if (el.bypass) begin
          st_d = ST_TRIP; // R08
        end else if (tick) begin
          acc_d = done ? ACC_FULL[ACC_W-1:0] : acc_sum[ACC_W-1:0];
          if (done) st_d = ST_TRIP; // R23
        end
      end
      ST_TRIP: begin
        if (!run) begin
          st_d = ST_IDLE;
          acc_d = '0;
        end
      end
      default: begin
        st_d = ST_IDLE;
        acc_d = '0;
      end
    endcase
  end

  // pickup register and state
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pk_q <= 1'b0;
      st_q <= ST_IDLE;
      acc_q <= '0;
    end else begin
      pk_q <= el.enable & pickup_next(el.current, el.pickup, pk_q); // R19
      st_q <= st_d;
      acc_q <= acc_d;
    end
  end

  assign el.picked = run;
  assign el.trip = (st_q == ST_TRIP);
endmodule // timed_element
`default_nettype wire

//--- testbench/overcurrent_supervision_assertions.sv
// checker on the top ports: bus, pickup and trip
// assumes one clock; bound at the foot
`timescale 1ns/100ps
`default_nettype none
module ocp_checker (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [ocp_pkg::CUR_W-1:0] phase_current,
  input wire logic [ocp_pkg::CUR_W-1:0] negseq_current,
  input wire logic single_pole_open_block,
  input wire logic [2:0] instant_pickup,
  input wire logic [2:0] instant_trip,
  input wire logic [2:0] timed_pickup,
  input wire logic [2:0] timed_trip
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // --------
  // bus
  // --------
  chk_ready_high: assert property (psel && penable |-> pready)
    else $error("pready low");
  chk_err_mapped: assert property (psel && penable && paddr <= 8'h24 && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("mapped error");
  // idle bus keeps the last read word
  chk_rdata_hold: assert property (!psel && !$past(psel) |-> $stable(prdata))
    else $error("idle rdata moved");
  chk_reset_quiet: assert property ($rose(arst_n) |-> instant_trip == 3'h0 && timed_trip == 3'h0)
    else $error("trip at reset");
  // --------
  // elements
  // --------
  // two sync stages; the pole gate acts after the instant pickup register, before the timed one
  chk_pole_inst: assert property (
    single_pole_open_block [*4] |-> instant_pickup[2:1] == 2'h0)
    else $error("pole inst pickup");
  chk_pole_timed: assert property (
    single_pole_open_block [*6] |-> timed_pickup[2:1] == 2'h0)
    else $error("pole timed pickup");
  chk_pick_phase: assert property (
    instant_pickup[0] |-> $past(phase_current) != 16'h0000)
    else $error("pickup no current");
  chk_tpick_neg: assert property (
    timed_pickup[2] |-> $past(negseq_current, 2) != 16'h0000)
    else $error("tpickup no current");
  chk_trip_pick: assert property (
    $rose(timed_trip[0]) |-> $past(timed_pickup[0]))
    else $error("trip no pickup");
endmodule // ocp_checker
bind overcurrent_supervision ocp_checker ocp_checker_i (.clk_sys, .arst_n, .psel, .penable,
  .paddr, .prdata, .pready, .pslverr, .phase_current, .negseq_current,
  .single_pole_open_block, .instant_pickup, .instant_trip, .timed_pickup, .timed_trip);
`default_nettype wire

//--- testbench/ocp_front_end.sv
// front end model: rms currents and directional flags
// assumes the block shares this clock
`timescale 1ns/100ps
`default_nettype none
module ocp_front_end (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic slow,
  input wire logic [2:0][ocp_pkg::CUR_W-1:0] cur_cmd,
  input wire logic [3:0] fwd_cmd,
  input wire logic [3:0] rev_cmd,
  output logic [ocp_pkg::CUR_W-1:0] phase_current,
  output logic [ocp_pkg::CUR_W-1:0] ground_current,
  output logic [ocp_pkg::CUR_W-1:0] negseq_current,
  output logic [3:0] fwd_flags,
  output logic [3:0] rev_flags
);
  import ocp_pkg::*;
  logic [1:0] div_q;
  wire logic upd = !slow || div_q == 2'h0;
  // slow mode: refresh every fourth cycle, a lagging filter
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 2'h0;
      {phase_current, ground_current, negseq_current, fwd_flags, rev_flags} <= '0;
    end else begin
      div_q <= div_q + 2'h1;
      if (upd) begin
        {negseq_current, ground_current, phase_current} <= cur_cmd;
        fwd_flags <= fwd_cmd;
        rev_flags <= rev_cmd;
      end
    end
  end
endmodule // ocp_front_end
`default_nettype wire

//--- testbench/test_overcurrent_inverse_time_supervision.sv
// self-checking bench of the supervision block
// assumes package, design, checker and model compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module test_overcurrent_inverse_time_supervision;
  import ocp_pkg::*;
  typedef struct {int el, tq, src, cur, fwd, rev, tdis, pu;} row_t;
  localparam int LIMIT = 95000;
  localparam logic [31:0] EN = 32'h0010_0000;
  logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, pole, slow, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, w;
  logic [2:0][CUR_W-1:0] cur_cmd;
  logic [CUR_W-1:0] ph_cur, gn_cur, ng_cur;
  logic [3:0] fwd_cmd, rev_cmd, fwd, rev;
  logic [2:0] itd, ttd, byp, ipu, itr, tpu, ttr;
  logic [5:0] blk;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  row_t r;
  // el, torque, src, cur, fwd, rev, disable, pickup
  row_t rows [15] = '{'{0,0,0,106,0,0,0,1}, '{0,0,0,105,0,0,0,0}, '{0,0,0,106,0,0,7,1},
    '{0,1,0,106,1,0,0,1}, '{0,1,0,106,2,0,0,0}, '{0,1,1,106,2,0,0,1}, '{0,2,0,106,0,1,0,1},
    '{0,2,0,106,1,0,0,0}, '{0,1,0,106,1,0,7,0}, '{0,3,0,200,15,15,0,0}, '{1,1,0,106,4,0,0,1},
    '{1,1,1,106,8,0,0,1}, '{1,1,1,106,4,0,0,0}, '{2,1,0,106,8,0,0,1}, '{2,1,1,106,4,0,0,0}};
  ocp_front_end ocp_front_end_i (.clk_sys, .arst_n, .slow,
    .cur_cmd, .fwd_cmd, .rev_cmd, .phase_current(ph_cur),
    .ground_current(gn_cur), .negseq_current(ng_cur), .fwd_flags(fwd), .rev_flags(rev));
  overcurrent_supervision overcurrent_supervision_i (.clk_sys, .arst_n,
    .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .phase_current(ph_cur),
    .ground_current(gn_cur), .negseq_current(ng_cur), .instant_forward_indication(fwd),
    .instant_reverse_indication(rev), .timed_forward_indication(fwd),
    .timed_reverse_indication(rev), .instant_torque_disable(itd),
    .timed_torque_disable(ttd), .single_pole_open_block(pole), .bypass_time(byp),
    .block_trip(blk), .instant_pickup(ipu), .instant_trip(itr), .timed_pickup(tpu),
    .timed_trip(ttr));
  // ------------
  // tasks
  // ------------
  task automatic wait_n(int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // one apb transfer, held until pready
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // timed phase element; long curves get a no-early-trip check only
  task automatic run(int crv, int dial, int cur, int pre, int us);
    int n = 0;
    int lim;
    lim = (us * 25 > 20000) ? 3000 : us * 27 + 50;
    cur_cmd <= '0;
    wait_n(6);
    apb(1'b1, 8'h18, 32'(crv * 1024 + dial));
    apb(1'b1, 8'h0C, EN | 32'h0000_0064);
    slow <= 1'b1;
    cur_cmd[0] <= CUR_W'(cur);
    if (pre > 0) begin
      wait_n(pre);
      cur_cmd[0] <= '0;
      wait_n(8);
      cur_cmd[0] <= CUR_W'(cur);
    end
    while (ttr[0] !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    if (us * 25 > 20000) `CHK("early trip", 1'b0, ttr[0])
    else `CHK("trip time", 1'b1, 1'(n >= us * 23 && n <= us * 27 + 20))
    slow <= 1'b0;
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ------------
  // clock, timeout, sequence
  // ------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    arst_n = 1'b0;
    {psel, penable, pwrite, pole, slow, paddr, pwdata, cur_cmd} = '0;
    {fwd_cmd, rev_cmd, itd, ttd, byp, blk} = '0;
    wait_n(16);
    arst_n <= 1'b1;
    apb(1'b0, 8'h00, '0);
    `CHK("cfg0 reset", 32'h0000_0000, rd)
    apb(1'b0, 8'h18, '0);
    `CHK("dset0 reset", 32'h0000_0064, rd)
    apb(1'b1, 8'h28, 32'hFFFF_FFFF);
    `CHK("unmapped err", 1'b1, err)
    // same word to instant and timed element
    foreach (rows[i]) begin
      r = rows[i];
      w = EN | 32'(r.src * 262144 + r.tq * 65536 + 100);
      cur_cmd <= '0;
      apb(1'b1, 8'(r.el * 4), w);
      apb(1'b1, 8'(r.el * 4 + 12), w);
      fwd_cmd <= 4'(r.fwd);
      rev_cmd <= 4'(r.rev);
      {itd, ttd} <= {2{3'(r.tdis)}};
      cur_cmd[r.el] <= CUR_W'(r.cur);
      wait_n(6);
      `CHK("instant pickup", 1'(r.pu), ipu[r.el])
      `CHK("instant trip", 1'(r.pu), itr[r.el])
      `CHK("timed pickup", 1'(r.pu), tpu[r.el])
    end
    // block trip needs its source enable
    cur_cmd <= '0;
    fwd_cmd <= '0;
    apb(1'b1, 8'h00, EN | 32'h0000_0064);
    blk <= 6'h01;
    cur_cmd[0] <= 16'h00C8;
    wait_n(6);
    `CHK("trip unsourced", 1'b1, itr[0])
    apb(1'b1, 8'h00, EN | 32'h0008_0064);
    cur_cmd[0] <= '0;
    wait_n(4);
    cur_cmd[0] <= 16'h00C8;
    wait_n(6);
    `CHK("trip blocked before", 1'b0, itr[0])
    blk <= 6'h00;
    wait_n(6);
    `CHK("trip unblocked", 1'b1, itr[0])
    blk <= 6'h01;
    wait_n(6);
    `CHK("trip reset by block", 1'b0, itr[0])
    blk <= 6'h00;
    // open pole silences ground and negseq
    apb(1'b1, 8'h04, EN | 32'h0000_0064);
    apb(1'b1, 8'h08, EN | 32'h0000_0064);
    cur_cmd <= {16'h00C8, 16'h00C8, 16'h00C8};
    wait_n(6);
    `CHK("pickup before pole", 3'h7, ipu)
    pole <= 1'b1;
    wait_n(6);
    `CHK("pickup with pole", 3'h1, ipu)
    pole <= 1'b0;
    // bypass makes a long-time curve trip at once
    for (int e = 0; e < 3; e++) begin
      apb(1'b1, 8'(e * 4 + 12), EN | 32'h0000_0064);
      apb(1'b1, 8'(e * 4 + 24), 32'h0000_0401);
      byp <= 3'(1 << e);
      wait_n(8);
      `CHK("bypass trip", 1'b1, ttr[e])
      byp <= 3'h0;
    end
    run(0, 5, 2000, 0, 368);
    run(0, 5, 4000, 0, 368);
    run(0, 5, 2000, 5000, 368);
    run(1, 1, 2000, 0, 63158);
    run(2, 1, 2000, 0, 3927);
    run(3, 1, 2000, 0, 122407);
    run(4, 1, 2000, 0, 22774);
    run(5, 1, 2000, 0, 494);
    run(6, 1, 2000, 0, 580);
    print_verdict();
  end
endmodule // test_overcurrent_inverse_time_supervision
`default_nettype wire
